// ---- ssp_pkg.sv ----
// Constants, register map and state type for the socket status and power register bank.
package ssp_pkg;

    // Byte offsets inside the bridge memory window and the matching I/O index values.
    localparam logic [11:0] SSP_ADDR_ID      = 12'h0800;
    localparam logic [11:0] SSP_ADDR_ST      = 12'h0801;
    localparam logic [11:0] SSP_ADDR_PC      = 12'h0802;
    localparam logic [3:0]  SSP_ADDR_PAGE    = 4'h8;
    localparam logic [7:0]  SSP_IDX_ID       = 8'h00;
    localparam logic [7:0]  SSP_IDX_ST       = 8'h01;
    localparam logic [7:0]  SSP_IDX_PC       = 8'h02;
    localparam logic [15:0] SSP_IO_DATA_OFS  = 16'h0001;
    localparam logic [7:0]  SSP_UNMAPPED_VAL = 8'h00;

    // Power control layout.
    localparam int          SSP_PC_OE_BIT    = 7;
    localparam int          SSP_PC_PWR_BIT   = 4;
    localparam int          SSP_PC_VCC_BIT   = 3;
    localparam int          SSP_PC_VPP_LSB   = 0;
    localparam logic [7:0]  SSP_PC_WR_MASK   = 8'h9B;
    localparam logic [7:0]  SSP_PC_RESET     = 8'h00;

    // Interface status layout.
    localparam int          SSP_ST_PWR_BIT   = 6;
    localparam int          SSP_ST_RDY_BIT   = 5;
    localparam int          SSP_ST_WP_BIT    = 4;
    localparam int          SSP_ST_CD2_BIT   = 3;
    localparam int          SSP_ST_CD1_BIT   = 2;
    localparam int          SSP_ST_B2_BIT    = 1;
    localparam int          SSP_ST_B1_BIT    = 0;

    // Identification layout.
    localparam logic [1:0]  SSP_ID_RSVD      = 2'b00;

    // Switch interface selector codes.
    localparam logic [1:0]  SSP_IF_RSVD      = 2'b00;
    localparam logic [1:0]  SSP_IF_PAR       = 2'b01;
    localparam logic [1:0]  SSP_IF_SER       = 2'b10;
    localparam logic [1:0]  SSP_IF_SMB       = 2'b11;

    // Serial switch frame: four bits, each clock half lasting SSP_SER_HALF cycles.
    localparam logic [3:0]  SSP_SER_HALF     = 4'h4;
    localparam logic [2:0]  SSP_SER_BITS     = 3'h4;
    localparam logic [3:0]  SSP_SMB_PAD      = 4'h0;

    // Synchroniser width: ready, wp, cd1, cd2, battery_level_one, battery_level_two, audio.
    localparam int          SSP_SYNC_W       = 7;

    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_SHIFT,
        SSP_LATCH
    } ssp_ser_state_t;

endpackage

// ---- ssp_socket_regs.sv ----
// Socket identification, interface status and power control registers with switch delivery.
`timescale 1ns/1ns
`default_nettype none

module ssp_socket_regs #(
    parameter logic [1:0] CARD_TYPE_CODE = 2'b10,  // Arbitrary value.
    parameter logic [3:0] STEPPING_CODE  = 4'h1    // Arbitrary value.
) (
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic [11:0] mem_addr_in,
    input  wire logic        mem_wr_in,
    input  wire logic        mem_rd_in,
    input  wire logic [7:0]  mem_wdata_in,
    output var  logic [7:0]  mem_rdata_out,
    output var  logic        mem_rvalid_out,
    input  wire logic [15:0] io_base_in,
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_wr_in,
    input  wire logic        io_rd_in,
    input  wire logic [7:0]  io_wdata_in,
    output var  logic [7:0]  io_rdata_out,
    output var  logic        io_rvalid_out,
    input  wire logic        id_override_en_in,
    input  wire logic [7:0]  id_override_value_in,
    input  wire logic [1:0]  power_if_sel_in,
    input  wire logic        io_card_in,
    input  wire logic        card_ready_in,
    input  wire logic        card_wp_in,
    input  wire logic        card_detect_one_n_in,
    input  wire logic        card_detect_two_n_in,
    input  wire logic        battery_level_one_in,
    input  wire logic        battery_level_two_in,
    input  wire logic        card_audio_n_in,
    input  wire logic        smb_busy_in,
    output var  logic        socket_output_en_out,
    output var  logic        sw_power_en_out,
    output var  logic        sw_vcc_3v3_out,
    output var  logic [1:0]  sw_vpp_sel_out,
    output var  logic        sw_sclk_out,
    output var  logic        sw_sdata_out,
    output var  logic        sw_latch_out,
    output var  logic        smb_req_out,
    output var  logic [7:0]  smb_data_out
);

    // Register state.
    logic [7:0]                    pc_q;
    logic [7:0]                    pc_d;
    logic [7:0]                    idx_q;
    logic [ssp_pkg::SSP_SYNC_W-1:0] sync1_q;
    logic [ssp_pkg::SSP_SYNC_W-1:0] sync2_q;
    logic [1:0]                    if_sel_q;
    logic                          pend_q;
    ssp_pkg::ssp_ser_state_t       ser_st_q;
    ssp_pkg::ssp_ser_state_t       ser_st_d;
    logic [3:0]                    ser_cnt_q;
    logic [2:0]                    ser_bit_q;
    logic [3:0]                    ser_word_q;

    // Live pins pass two flops; only the second stage feeds any logic.
    logic [ssp_pkg::SSP_SYNC_W-1:0] pins_raw;
    assign pins_raw = {card_audio_n_in, battery_level_two_in, battery_level_one_in,
                       card_detect_two_n_in, card_detect_one_n_in, card_wp_in, card_ready_in};

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    wire rdy_s   = sync2_q[0];
    wire wp_s    = sync2_q[1];
    wire cd1_n_s = sync2_q[2];
    wire cd2_n_s = sync2_q[3];
    wire battery_level_one_s  = sync2_q[4];
    wire battery_level_two_s  = sync2_q[5];
    wire aud_n_s = sync2_q[6];

    // Read values of the three registers.
    wire [7:0] id_fixed = {CARD_TYPE_CODE, ssp_pkg::SSP_ID_RSVD, STEPPING_CODE};
    wire [7:0] id_val   = id_override_en_in ? id_override_value_in : id_fixed;
    // Only bit 1 follows the card: I/O cards give speaker, others battery level two; bit 0 is always battery level one.
    wire       st_b1    = io_card_in ? aud_n_s : battery_level_two_s;
    wire [7:0] st_val   = {1'b0, pc_q[ssp_pkg::SSP_PC_PWR_BIT], rdy_s, wp_s,
                           ~cd2_n_s, ~cd1_n_s, st_b1, battery_level_one_s};
    wire [7:0] pc_val   = pc_q & ssp_pkg::SSP_PC_WR_MASK;

    function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic [7:0] idv,
                                            input logic [7:0] stv, input logic [7:0] pcv);
        logic [7:0] r;
        r = ssp_pkg::SSP_UNMAPPED_VAL;
        case (idx)
            ssp_pkg::SSP_IDX_ID: r = idv;
            ssp_pkg::SSP_IDX_ST: r = stv;
            ssp_pkg::SSP_IDX_PC: r = pcv;
            default:             r = ssp_pkg::SSP_UNMAPPED_VAL;
        endcase
        return r;
    endfunction

    // Address decode for both access paths.
    wire       mem_in_page = (mem_addr_in[11:8] == ssp_pkg::SSP_ADDR_PAGE);
    wire [7:0] mem_idx     = mem_in_page ? mem_addr_in[7:0] : 8'hFF;
    wire       mem_pc_wr   = mem_wr_in && (mem_addr_in == ssp_pkg::SSP_ADDR_PC);
    wire       io_idx_hit  = (io_addr_in == io_base_in);
    wire       io_data_hit = (io_addr_in == io_base_in + ssp_pkg::SSP_IO_DATA_OFS);
    wire       io_pc_wr    = io_wr_in && io_data_hit && (idx_q == ssp_pkg::SSP_IDX_PC);
    wire       pc_wr       = mem_pc_wr || io_pc_wr;
    // The memory path wins if both paths write in one cycle.
    wire [7:0] pc_wdata    = mem_pc_wr ? mem_wdata_in : io_wdata_in;
    wire [7:0] mem_rval    = read_reg(mem_idx, id_val, st_val, pc_val);
    wire [7:0] io_dval     = read_reg(idx_q, id_val, st_val, pc_val);
    wire [7:0] io_rval     = io_idx_hit ? idx_q : (io_data_hit ? io_dval : ssp_pkg::SSP_UNMAPPED_VAL);

    assign pc_d = pc_wr ? (pc_wdata & ssp_pkg::SSP_PC_WR_MASK) : pc_q;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pc_q           <= ssp_pkg::SSP_PC_RESET;
            idx_q          <= 8'h00;
            mem_rdata_out  <= 8'h00;
            mem_rvalid_out <= 1'b0;
            io_rdata_out   <= 8'h00;
            io_rvalid_out  <= 1'b0;
        end else begin
            pc_q           <= pc_d;
            idx_q          <= (io_wr_in && io_idx_hit) ? io_wdata_in : idx_q;
            mem_rdata_out  <= mem_rd_in ? mem_rval : mem_rdata_out;
            mem_rvalid_out <= mem_rd_in;
            io_rdata_out   <= io_rd_in ? io_rval : io_rdata_out;
            io_rvalid_out  <= io_rd_in;
        end
    end

    // Switch delivery: under the parallel, serial or bus selector, a change of settings or of interface selector starts a new update.
    wire [3:0] pwr_word  = {pc_q[ssp_pkg::SSP_PC_PWR_BIT], pc_q[ssp_pkg::SSP_PC_VCC_BIT],
                            pc_q[ssp_pkg::SSP_PC_VPP_LSB+1], pc_q[ssp_pkg::SSP_PC_VPP_LSB]};
    wire       pwr_chg   = pc_wr || (power_if_sel_in != if_sel_q);
    wire       is_par    = (if_sel_q == ssp_pkg::SSP_IF_PAR);
    wire       is_ser    = (if_sel_q == ssp_pkg::SSP_IF_SER);
    wire       is_smb    = (if_sel_q == ssp_pkg::SSP_IF_SMB);
    wire       ser_start = pend_q && is_ser && (ser_st_q == ssp_pkg::SSP_IDLE);
    wire       smb_start = pend_q && is_smb && !smb_busy_in;
    wire       half_end  = (ser_cnt_q == ssp_pkg::SSP_SER_HALF - 4'h1);
    wire       bit_end   = (ser_cnt_q == {ssp_pkg::SSP_SER_HALF[2:0], 1'b0} - 4'h1);
    wire       last_bit  = (ser_bit_q == ssp_pkg::SSP_SER_BITS - 3'h1);
    // A change in the same cycle as a launch keeps the request pending.
    wire       pend_d    = pwr_chg || (pend_q && !ser_start && !smb_start && !is_par);

    always_comb begin
        ser_st_d = ser_st_q;
        case (ser_st_q)
            ssp_pkg::SSP_IDLE:  ser_st_d = ser_start ? ssp_pkg::SSP_SHIFT : ssp_pkg::SSP_IDLE;
            ssp_pkg::SSP_SHIFT: ser_st_d = (bit_end && last_bit) ? ssp_pkg::SSP_LATCH : ssp_pkg::SSP_SHIFT;
            ssp_pkg::SSP_LATCH: ser_st_d = half_end ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_LATCH;
            default:            ser_st_d = ssp_pkg::SSP_IDLE;
        endcase
    end

    wire       in_shift  = (ser_st_q == ssp_pkg::SSP_SHIFT);
    wire       cnt_wrap  = (in_shift && bit_end) || (ser_st_q == ssp_pkg::SSP_LATCH && half_end);
    wire [3:0] ser_cnt_d = (ser_st_q == ssp_pkg::SSP_IDLE || cnt_wrap) ? 4'h0 : ser_cnt_q + 4'h1;
    wire [2:0] ser_bit_d = ser_start ? 3'h0 : ((in_shift && bit_end) ? ser_bit_q + 3'h1 : ser_bit_q);
    wire [3:0] word_d    = ser_start ? pwr_word : ser_word_q;
    wire       sclk_d    = in_shift && (ser_st_d == ssp_pkg::SSP_SHIFT) && (ser_cnt_d >= ssp_pkg::SSP_SER_HALF);
    wire       sdata_d   = (ser_st_d == ssp_pkg::SSP_SHIFT) ? word_d[3 - ser_bit_d[1:0]] : 1'b0;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            if_sel_q   <= ssp_pkg::SSP_IF_PAR;
            pend_q     <= 1'b1;
            ser_st_q   <= ssp_pkg::SSP_IDLE;
            ser_cnt_q  <= 4'h0;
            ser_bit_q  <= 3'h0;
            ser_word_q <= 4'h0;
        end else begin
            if_sel_q   <= power_if_sel_in;
            pend_q     <= pend_d;
            ser_st_q   <= ser_st_d;
            ser_cnt_q  <= ser_cnt_d;
            ser_bit_q  <= ser_bit_d;
            ser_word_q <= word_d;
        end
    end

    // Registered pin drivers toward the socket and the power switch.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            socket_output_en_out <= 1'b0;
            sw_power_en_out      <= 1'b0;
            sw_vcc_3v3_out       <= 1'b0;
            sw_vpp_sel_out       <= 2'b00;
            sw_sclk_out          <= 1'b0;
            sw_sdata_out         <= 1'b0;
            sw_latch_out         <= 1'b0;
            smb_req_out          <= 1'b0;
            smb_data_out         <= 8'h00;
        end else begin
            socket_output_en_out <= pc_d[ssp_pkg::SSP_PC_OE_BIT];
            sw_power_en_out      <= is_par && pc_q[ssp_pkg::SSP_PC_PWR_BIT];
            sw_vcc_3v3_out       <= is_par && pc_q[ssp_pkg::SSP_PC_VCC_BIT];
            sw_vpp_sel_out       <= is_par ? pc_q[ssp_pkg::SSP_PC_VPP_LSB+:2] : 2'b00;
            sw_sclk_out          <= sclk_d;
            sw_sdata_out         <= sdata_d;
            sw_latch_out         <= (ser_st_d == ssp_pkg::SSP_LATCH);
            smb_req_out          <= smb_start;
            smb_data_out         <= smb_start ? {ssp_pkg::SSP_SMB_PAD, pwr_word} : smb_data_out;
        end
    end

    // Helper state for the checks: which register the previous memory read hit.
    logic [7:0] chk_idx_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chk_idx_q <= 8'hFF;
        end else begin
            chk_idx_q <= mem_idx;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    id_fixed_read_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ID && !id_override_en_in
        |=> mem_rdata_out == {CARD_TYPE_CODE, 2'b00, STEPPING_CODE})
        else $error("identification read wrong");
    id_override_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ID && id_override_en_in
        |=> mem_rdata_out == $past(id_override_value_in))
        else $error("identification override ignored");
    pwr_active_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ST
        |=> mem_rdata_out[6] == $past(pc_q[4]) && mem_rdata_out[7] == 1'b0)
        else $error("power active bit wrong");
    ready_mirror_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ST
        |=> mem_rdata_out[5] == $past(card_ready_in, 3))
        else $error("ready bit not synchronised pin");
    detect_bits_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ST
        |=> mem_rdata_out[3:2] == ~{$past(card_detect_two_n_in, 3), $past(card_detect_one_n_in, 3)})
        else $error("card detect bits wrong");
    pc_reserved_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_PC
        |=> mem_rdata_out[6:5] == 2'b00 && mem_rdata_out[2] == 1'b0)
        else $error("reserved power bits not zero");
    oe_follow_a: assert property (pc_wr
        |=> socket_output_en_out == $past(pc_wdata[7]) && pc_q[7] == $past(pc_wdata[7]))
        else $error("output enable did not follow write");
    ro_write_a: assert property (!pc_wr |=> $stable(pc_q))
        else $error("power control changed without write");
    par_drive_a: assert property (is_par && $stable(pc_q) && $stable(if_sel_q)
        |=> sw_power_en_out == $past(pc_q[4]) && sw_vcc_3v3_out == $past(pc_q[3])
            && sw_vpp_sel_out == $past(pc_q[1:0]))
        else $error("parallel switch drive wrong");
    ser_frame_a: assert property (ser_start |-> ##[33:34] sw_latch_out)
        else $error("serial frame latch late");
    // Status pins reach the read register three edges after the pin is sampled.
    status_pins_a: assert property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ST
        |=> mem_rdata_out[4] == $past(card_wp_in, 3) && mem_rdata_out[0] == $past(battery_level_one_in, 3)
            && mem_rdata_out[1] == ($past(io_card_in) ? $past(card_audio_n_in, 3) : $past(battery_level_two_in, 3)))
        else $error("status pin bits wrong");
    unmapped_read_a: assert property (mem_rvalid_out && chk_idx_q > ssp_pkg::SSP_IDX_PC
        |-> mem_rdata_out == ssp_pkg::SSP_UNMAPPED_VAL)
        else $error("unmapped read not zero");
    io_index_a: assert property (io_rd_in && io_idx_hit |=> io_rdata_out == $past(idx_q))
        else $error("index port read wrong");
    smb_word_a: assert property (smb_start |=> smb_req_out && smb_data_out == {4'h0, $past(pc_q[4:3]), $past(pc_q[1:0])})
        else $error("switch bus word wrong");
    sclk_idle_a: assert property (!in_shift |=> !sw_sclk_out)
        else $error("serial clock outside frame");

    par_update_c: cover property (pc_wr && is_par ##1 sw_power_en_out);
    ser_update_c: cover property (ser_start ##[1:40] sw_latch_out);
    smb_update_c: cover property (smb_req_out);
    io_path_c: cover property (io_pc_wr ##1 io_rd_in && io_data_hit);
    io_card_read_c: cover property (mem_rd_in && mem_idx == ssp_pkg::SSP_IDX_ST && io_card_in);

endmodule

`default_nettype wire

// ---- ssp_socket_model.sv ----
// Socket side model: card pins with pull-ups and a serial power switch receiver.
`timescale 1ns/1ns
`default_nettype none
module ssp_socket_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] seat_in,
    input  wire logic [4:0] pins_in,
    input  wire logic       sclk_in,
    input  wire logic       sdata_in,
    input  wire logic       latch_in,
    output var  logic [1:0] cd_n_out,
    output var  logic [4:0] pins_out,
    output var  logic [3:0] frame_out,
    output var  int         frames_out
);
    logic [3:0] shift_q = 4'h0;
    logic       sclk_q  = 1'b0;
    logic       latch_q = 1'b0;
    initial frames_out = 0;
    initial frame_out = 4'h0;
    always @(posedge clk_in) begin
        cd_n_out <= ~seat_in;
        // With no card seated the lines float and sit at their pull-ups.
        pins_out <= (seat_in == 2'b00) ? 5'h1F : pins_in;
        sclk_q   <= sclk_in;
        latch_q  <= latch_in;
        if (sclk_in && !sclk_q) begin
            shift_q <= {shift_q[2:0], sdata_in};
        end
        if (latch_in && !latch_q) begin
            frame_out  <= shift_q;
            frames_out <= frames_out + 1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the socket status and power register bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [1:0]  ID_TYPE = 2'b10;  // Arbitrary value.
    localparam logic [3:0]  ID_STEP = 4'h1;   // Arbitrary value.
    localparam logic [15:0] BASE    = 16'h03E0;
    logic clk_sys_in = 1'b0, resetn_in = 1'b0;
    logic [11:0] mem_addr_in = 12'h000;
    logic mem_wr_in = 1'b0, mem_rd_in = 1'b0, io_wr_in = 1'b0, io_rd_in = 1'b0;
    logic [7:0] mem_wdata_in = 8'h00, io_wdata_in = 8'h00, id_val = 8'h00, mem_rdata_out, io_rdata_out;
    logic [15:0] io_addr_in = 16'h0000;
    logic id_en = 1'b0, io_card = 1'b0, smb_busy = 1'b0, mem_rvalid_out, io_rvalid_out;
    logic [1:0] if_sel = 2'b01, seat = 2'b00, cd_n, vpp;
    logic [4:0] pin_v = 5'h00, pins;
    logic oe, pwr, vcc, sclk, sdata, latch, smb_req, seen;
    logic [7:0] smb_data, pc_v, wd;
    logic [3:0] frame;
    int frames, mismatches = 0, n_compared = 0, cycles = 0;
    logic [7:0] exp_q[$];

    initial forever #2 clk_sys_in = ~clk_sys_in;

    ssp_socket_regs #(.CARD_TYPE_CODE(ID_TYPE), .STEPPING_CODE(ID_STEP)) DUT (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .mem_addr_in(mem_addr_in), .mem_wr_in(mem_wr_in),
        .mem_rd_in(mem_rd_in), .mem_wdata_in(mem_wdata_in), .mem_rdata_out(mem_rdata_out),
        .mem_rvalid_out(mem_rvalid_out), .io_base_in(BASE), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .io_rvalid_out(io_rvalid_out), .id_override_en_in(id_en), .id_override_value_in(id_val),
        .power_if_sel_in(if_sel), .io_card_in(io_card), .card_ready_in(pins[4]), .card_wp_in(pins[3]),
        .card_detect_one_n_in(cd_n[0]), .card_detect_two_n_in(cd_n[1]), .battery_level_one_in(pins[1]),
        .battery_level_two_in(pins[2]), .card_audio_n_in(pins[0]), .smb_busy_in(smb_busy),
        .socket_output_en_out(oe), .sw_power_en_out(pwr), .sw_vcc_3v3_out(vcc), .sw_vpp_sel_out(vpp),
        .sw_sclk_out(sclk), .sw_sdata_out(sdata), .sw_latch_out(latch), .smb_req_out(smb_req),
        .smb_data_out(smb_data));

    ssp_socket_model socket (
        .clk_in(clk_sys_in), .seat_in(seat), .pins_in(pin_v), .sclk_in(sclk), .sdata_in(sdata),
        .latch_in(latch), .cd_n_out(cd_n), .pins_out(pins), .frame_out(frame), .frames_out(frames));

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic end_of_test();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One strobe cycle, then every strobe drops together.
    task automatic bus(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        if (io) begin
            io_addr_in  <= a;
            io_wr_in    <= wr;
            io_rd_in    <= !wr;
            io_wdata_in <= d;
        end else begin
            mem_addr_in  <= a[11:0];
            mem_wr_in    <= wr;
            mem_rd_in    <= !wr;
            mem_wdata_in <= d;
        end
        @(posedge clk_sys_in);
        {mem_wr_in, mem_rd_in, io_wr_in, io_rd_in} <= 4'h0;
    endtask

    task automatic rd(input logic io, input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(io, 1'b0, a, 8'h00);
    endtask

    function automatic logic [7:0] st_exp();
        logic [4:0] pv;
        pv = (seat == 2'b00) ? 5'h1F : pin_v;
        return {1'b0, pc_v[4], pv[4], pv[3], seat[1], seat[0], io_card ? pv[0] : pv[2], pv[1]};
    endfunction

    function automatic logic [3:0] sw_exp();
        return {pc_v[4], pc_v[3], pc_v[1:0]};
    endfunction

    // Read answers are matched against the oldest outstanding expectation.
    always @(posedge clk_sys_in) begin
        if (mem_rvalid_out === 1'b1 || io_rvalid_out === 1'b1)
            check(mem_rvalid_out ? mem_rdata_out : io_rdata_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        pc_v = 8'h00;
        void'($urandom(21192));
        repeat (12) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        rd(1'b0, 16'h0800, {ID_TYPE, 2'b00, ID_STEP});
        rd(1'b0, 16'h0802, 8'h00);
        rd(1'b0, 16'h0801, st_exp());
        check({4'h0, oe, pwr, vpp}, 8'h00);
        bus(1'b0, 1'b1, 16'h0800, 8'hFF);
        bus(1'b0, 1'b1, 16'h0801, 8'hFF);
        rd(1'b0, 16'h0800, {ID_TYPE, 2'b00, ID_STEP});
        rd(1'b0, 16'h0803, 8'h00);
        id_en  <= 1'b1;
        id_val <= 8'($urandom);
        @(posedge clk_sys_in);
        rd(1'b0, 16'h0800, id_val);
        id_en <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            wd      = 8'($urandom);
            wd[1:0] = i[1:0];
            wd[3]   = i[2];
            pc_v    = wd & 8'h9B;
            seat    <= 2'($urandom);
            pin_v   <= 5'($urandom);
            io_card <= i[3];
            bus(1'b0, 1'b1, 16'h0802, wd);
            repeat (2) @(posedge clk_sys_in);
            check({3'b000, oe, pwr, vcc, vpp}, {3'b000, pc_v[7], sw_exp()});
            rd(1'b0, 16'h0802, pc_v);
            rd(1'b0, 16'h0801, st_exp());
        end
        wd = 8'($urandom);
        bus(1'b1, 1'b1, BASE, 8'h02);
        bus(1'b1, 1'b1, BASE + 16'h0001, wd);
        pc_v = wd & 8'h9B;
        rd(1'b1, BASE + 16'h0001, pc_v);
        rd(1'b1, BASE, 8'h02);
        rd(1'b0, 16'h0802, pc_v);
        if_sel <= 2'b10;
        for (int k = 0; k < 300 && frames < 1; k++) @(posedge clk_sys_in);
        check({4'h0, frame}, {4'h0, sw_exp()});
        bus(1'b0, 1'b1, 16'h0802, 8'h1A);
        pc_v = 8'h1A;
        for (int k = 0; k < 300 && frames < 2; k++) @(posedge clk_sys_in);
        check({3'b000, frames == 2, frame}, {4'h1, sw_exp()});
        check({6'h00, pwr, vcc}, 8'h00);
        smb_busy <= 1'b1;
        if_sel   <= 2'b11;
        bus(1'b0, 1'b1, 16'h0802, 8'h19);
        pc_v = 8'h19;
        seen = 1'b0;
        repeat (20) @(posedge clk_sys_in) seen = seen | (smb_req === 1'b1);
        check({7'h00, seen}, 8'h00);
        smb_busy <= 1'b0;
        for (int k = 0; k < 100 && smb_req !== 1'b1; k++) @(posedge clk_sys_in);
        check(smb_data, {4'h0, sw_exp()});
        if_sel <= 2'b00;
        bus(1'b0, 1'b1, 16'h0802, 8'h9A);
        seen = 1'b0;
        repeat (40) @(posedge clk_sys_in) seen = seen | (smb_req === 1'b1) | (latch === 1'b1);
        check({5'h00, seen, frames == 2, pwr}, 8'h02);
        check({7'h00, oe}, 8'h01);
        repeat (10) @(posedge clk_sys_in);
        check({7'h00, exp_q.size() == 0}, 8'h01);
        end_of_test();
    end
endmodule
`default_nettype wire
